// file: sim/dac_link_sva.sv
`timescale 1ns/100ps
module dac_link_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Two-wire lines and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n,
  // Converter side of the device
  input wire logic [7:0] conv_data,
  input wire logic power_down_sel_hi,
  input wire logic power_down_sel_lo,
  input wire logic powered_down,
  input wire logic hs_mode,
  input wire logic update_pulse
);
  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence start_cond; scl && $fell(sda); endsequence
  sequence stop_cond; scl && $rose(sda); endsequence
  sequence ack_begin; $fell(dev_sda_oe_n); endsequence

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Reset is checked without the default disable, since it is the cause here
  AST_RESET_ZERO: assert property (disable iff (1'b0) rst |=> conv_data == 8'h00)
    else $error("converter code not cleared by reset");
  AST_ACK_SCL_LOW: assert property (ack_begin |-> !scl)
    else $error("acknowledge started while clock high");
  AST_ACK_LONG: assert property (ack_begin |-> ##1 (!dev_sda_oe_n) [*8])
    else $error("acknowledge too short");
  AST_REL_SCL_LOW: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("acknowledge released while clock high");
  // The device is the transmitter during acknowledge, so its drive must not move while the clock is high
  AST_HOLD_HIGH: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device drive changed while clock high");
  AST_FREE_AT_START: assert property (start_cond |-> dev_sda_oe_n)
    else $error("device driving data at start");
  AST_STOP_HS: assert property (stop_cond |-> ##[1:8] !hs_mode)
    else $error("high-speed setting kept after stop");
  AST_HS_NO_ACK: assert property ($rose(hs_mode) |-> dev_sda_oe_n [*8])
    else $error("high-speed code acknowledged");
  AST_UPD_FALL: assert property (update_pulse |-> !scl && $past(scl, 8))
    else $error("update not tied to a clock fall");
  AST_UPD_CAUSE: assert property ($changed(conv_data) |-> update_pulse)
    else $error("converter code changed without update");
  AST_PD_FLAG: assert property (update_pulse |->
    powered_down == (power_down_sel_hi | power_down_sel_lo))
    else $error("power-down flag disagrees with field");
  COV_HS: cover property ($rose(hs_mode));
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import dac_link_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [31:0] GO = 32'h1 << CMD_GO;
  localparam logic [31:0] HS = 32'h1 << CMD_HS;
  localparam logic [31:0] BC = 32'h1 << CMD_BCAST;
  localparam logic [31:0] SEL = 32'h1 << CMD_SEL;
  localparam logic [31:0] STP = 32'h1 << CMD_STOP;
  logic mclk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic addr_select_pin;
  logic [7:0] conv_data;
  logic power_down_sel_hi;
  logic power_down_sel_lo;
  logic powered_down;
  logic hs_mode;
  logic update_pulse;
  logic [31:0] st;
  int errors;
  int n_tests;

  // The single slave closes its own data phase
  assign hready = hreadyout;
  dac_link_if link();
  dac_link_host dac_link_host_i (.mclk(mclk), .rst(rst), .bus(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  dac_link_device dac_link_device_i (.mclk(mclk), .rst(rst), .bus(link),
    .addr_select_pin(addr_select_pin), .conv_data(conv_data),
    .power_down_sel_hi(power_down_sel_hi), .power_down_sel_lo(power_down_sel_lo),
    .powered_down(powered_down), .hs_mode(hs_mode), .update_pulse(update_pulse));
  dac_link_sva dac_link_sva_i (.mclk(mclk), .rst(rst), .scl(link.scl), .sda(link.sda),
    .dev_sda_oe_n(link.dev_sda_oe_n), .conv_data(conv_data),
    .power_down_sel_hi(power_down_sel_hi), .power_down_sel_lo(power_down_sel_lo),
    .powered_down(powered_down), .hs_mode(hs_mode), .update_pulse(update_pulse));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Load a pair, start it, poll until idle; the extra cycles cover the update delay
  task automatic run(input logic [31:0] cmd, input logic [31:0] data,
                     output logic [31:0] sts);
    int i;
    ahb(1'b1, REG_DATA, data, sts);
    ahb(1'b1, REG_CMD, cmd, sts);
    i = 0;
    sts = 32'h1;
    while (sts[ST_BUSY] !== 1'b0 && i < 20000) begin
      ahb(1'b0, REG_STATUS, 32'h0, sts);
      i++;
    end
    if (i >= 20000) begin
      errors++;
      $display("unexpected busy: expected 0, seen 1");
      stop_test();
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic chk_dev(input logic [7:0] code, input logic [1:0] pd);
    chk8("conv_data", code, conv_data);
    chk8("pd_field", {6'h0, pd}, {6'h0, power_down_sel_hi, power_down_sel_lo});
    chk8("powered_down", {7'h0, pd != 2'h0}, {7'h0, powered_down});
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run needs about 55k cycles; this allows about 90k
  initial begin
    #720000;
    errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    addr_select_pin = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_dev(8'h00, 2'h0);
    chk8("hs_mode", 8'h00, {7'h0, hs_mode});
    ahb(1'b0, REG_STATUS, 32'h0, st);
    chk32("status", 32'h0, st);
    ahb(1'b1, 32'h0000_0040, 32'hffff_ffff, st);
    ahb(1'b0, 32'h0000_0040, 32'h0, st);
    chk32("unmapped", 32'h0, st);
    chk32("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    // Own address with the strapped select bit
    run(GO | SEL | STP, 32'ha5, st);
    chk32("nack_match", 32'h0, st & (32'h1 << ST_NACK));
    chk_dev(8'ha5, 2'h0);
    // Wrong select bit: refused, code untouched
    run(GO | STP, 32'h3c, st);
    chk32("nack_miss", 32'h1 << ST_NACK, st & (32'h1 << ST_NACK));
    chk_dev(8'ha5, 2'h0);
    // Strap moves after power-up; the latched select bit must not follow it
    addr_select_pin <= 1'b0;
    // Broadcast through every power-down mode, code kept
    for (int pd = 0; pd < 4; pd++) begin
      run(GO | BC | STP, (32'(pd) << DATA_PD_LSB) | 32'ha5, st);
      chk_dev(8'ha5, 2'(pd));
    end
    // High-speed code first, frame left open
    run(GO | HS | SEL, 32'h5a, st);
    chk32("status_hs", (32'h1 << ST_OPEN) | (32'h1 << ST_HS), st);
    chk8("hs_mode", 8'h01, {7'h0, hs_mode});
    chk_dev(8'h5a, 2'h0);
    // Second pair in the same frame, then stop
    run(GO | STP, 32'h81, st);
    chk_dev(8'h81, 2'h0);
    chk32("status_end", 32'h0, st & ~(32'h1 << ST_NACK));
    chk8("hs_mode", 8'h00, {7'h0, hs_mode});
    stop_test();
  end
endmodule

// file: src/dac_link_device.sv
// Contract
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Transmitter holds data stable while clock high
// - Acknowledge address only when it matches
// - Nine-clock groups: eight bits plus acknowledge
// - After stop, ignore bus until matched start
// - Detect high-speed code, never acknowledge it
// - Repeated start continues; stop ends high-speed
// - Master prefers repeated starts in high-speed
// - Acknowledge address, control and low bytes
// - Update on falling edge ending low acknowledge
// - Further updates need only byte pairs
// - Own address is 100110, select, zero
// - Select bit latched at power-up
// - Answer broadcast address regardless of select
// - Control byte: power-down field and upper nibble
// - Low byte upper nibble is data, rest ignored
// - Power-down field encodes four output modes
// - Data register clears to zero at reset
// - Power-down leaves data register unchanged; here power-down updates load conv_data too
// - No ten-bit or general call responses
`timescale 1ns/100ps
module dac_link_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Two-wire bus
  dac_link_if.device bus,
  // Address select strap
  input wire logic addr_select_pin,
  // Converter side
  output logic [7:0] conv_data,
  output logic power_down_sel_hi,
  output logic power_down_sel_lo,
  output logic powered_down,
  output logic hs_mode,
  output logic update_pulse
);
  import dac_link_pkg::*;

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic scl_d;
  logic sda_d;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  pin_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({bus.scl, bus.sda, addr_select_pin}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, sel_s} = pins_s;

  // Previous synchronised levels for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Both lines pass the same flops, so their order is preserved
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // ----------------------------------------
  // Address strap
  // ----------------------------------------
  logic [1:0] strap_cnt;
  logic strap_ok;
  logic addr_sel;

  // Caught once the synchroniser holds real pin levels after reset release
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_cnt <= 2'h0;
      strap_ok <= 1'b0;
      addr_sel <= 1'b0;
    end else if (!strap_ok) begin
      if (strap_cnt == STRAP_WAIT) begin
        addr_sel <= sel_s;
        strap_ok <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // Own address or broadcast; general call and ten-bit headers never match
  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b == {ADDR_FIXED, sel, 1'b0}) || (b == BCAST_ADDR);
  endfunction

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  dev_state_t state;
  dev_phase_t phase;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] ctrl_hold;
  logic [3:0] low_hold;
  logic upd_pend;
  logic apply;
  logic hs_code_seen;

  // Commit only at the fall that closes the acknowledge of the low byte
  assign apply = (state == D_ACK) && scl_fall && upd_pend
                 && !start_seen && !stop_seen;
  assign hs_code_seen = (state == D_RECV) && (phase == P_ADDR) && scl_fall
                        && (bit_cnt == BITS_PER_BYTE)
                        && (shift[7:3] == HS_CODE_TOP);

  // A start aborts any half-received pair so a torn frame never updates
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= D_IDLE;
      phase <= P_ADDR;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ctrl_hold <= 8'h00;
      low_hold <= 4'h0;
      upd_pend <= 1'b0;
    end else if (start_seen) begin
      state <= D_RECV;
      phase <= P_ADDR;
      bit_cnt <= 4'h0;
      upd_pend <= 1'b0;
    end else if (stop_seen) begin
      state <= D_IDLE;
      upd_pend <= 1'b0;
    end else begin
      unique case (state)
        D_IDLE, D_SKIP: begin
          bit_cnt <= 4'h0;
        end
        D_RECV: begin
          if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            unique case (phase)
              P_ADDR: begin
                if (strap_ok && addr_match(shift, addr_sel)) begin
                  state <= D_ACK;
                  phase <= P_CTRL;
                end else begin
                  state <= D_SKIP;
                end
              end
              P_CTRL: begin
                ctrl_hold <= shift;
                state <= D_ACK;
                phase <= P_LOW;
              end
              P_LOW: begin
                low_hold <= shift[7:NIBBLE];
                state <= D_ACK;
                phase <= P_CTRL;
                upd_pend <= 1'b1;
              end
              default: begin
                state <= D_SKIP;
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            state <= D_RECV;
            bit_cnt <= 4'h0;
            upd_pend <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // One cycle behind the state; the clock is low far longer than that
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus.dev_sda_oe_n <= 1'b1;
      bus.dev_sda_out <= 1'b0;
    end else begin
      bus.dev_sda_oe_n <= (state != D_ACK);
      bus.dev_sda_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Speed setting
  // ----------------------------------------
  // Only a stop returns to standard/fast; repeated starts keep high speed
  always_ff @(posedge mclk) begin
    if (rst) begin
      hs_mode <= 1'b0;
    end else if (stop_seen) begin
      hs_mode <= 1'b0;
    end else if (hs_code_seen) begin
      hs_mode <= 1'b1;
    end
  end

  // ----------------------------------------
  // Converter register
  // ----------------------------------------
  // Reserved control bits are accepted without check
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_data <= 8'h00;
      power_down_sel_hi <= 1'b0;
      power_down_sel_lo <= 1'b0;
      powered_down <= 1'b0;
    end else if (apply) begin
      conv_data <= {ctrl_hold[NIBBLE-1:0], low_hold};
      {power_down_sel_hi, power_down_sel_lo} <= ctrl_hold[CTRL_PD_LSB +: 2];
      powered_down <= (ctrl_hold[CTRL_PD_LSB +: 2] != PD_NORMAL);
    end
  end

  // Strobe marks the cycle the new value takes effect
  always_ff @(posedge mclk) begin
    if (rst) begin
      update_pulse <= 1'b0;
    end else begin
      update_pulse <= apply;
    end
  end
endmodule

// file: src/dac_link_host.sv
`timescale 1ns/100ps
module dac_link_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Two-wire bus
  dac_link_if.host bus,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  import dac_link_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [CMD_W-1:0] cmd;
  logic [9:0] data_reg;
  host_state_t state;
  host_step_t step;
  logic nack;
  logic open;
  logic hs_active;
  logic wr_pend;
  logic [31:0] addr_q;
  logic go;

  function automatic logic [31:0] reg_read(input logic [31:0] a);
    reg_read = 32'h0000_0000;
    if (a == REG_CMD) reg_read[CMD_W-1:0] = cmd;
    if (a == REG_DATA) reg_read[9:0] = data_reg;
    if (a == REG_STATUS) begin
      reg_read[ST_BUSY] = (state != H_IDLE);
      reg_read[ST_NACK] = nack;
      reg_read[ST_OPEN] = open;
      reg_read[ST_HS] = hs_active;
    end
  endfunction

  // Zero wait states: read data is fetched at the address phase edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      addr_q <= haddr;
      if (hsel && htrans == HTRANS_NONSEQ && !hwrite) hrdata <= reg_read(haddr);
    end
  end

  // Commands written while busy are dropped
  assign go = wr_pend && addr_q == REG_CMD && hwdata[CMD_GO] && state == H_IDLE;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd <= '0;
      data_reg <= 10'h000;
    end else if (wr_pend && state == H_IDLE) begin
      if (addr_q == REG_CMD) cmd <= hwdata[CMD_W-1:0];
      if (addr_q == REG_DATA) data_reg <= hwdata[9:0];
    end
  end

  // ----------------------------------------
  // Quarter-bit divider
  // ----------------------------------------
  logic [6:0] qcnt;
  logic tick;
  assign tick = qcnt == ((hs_active ? HS_QTR_CYC : FS_QTR_CYC) - 7'h01);

  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      qcnt <= 7'h00;
    end else begin
      qcnt <= qcnt + 7'h01;
    end
  end

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  logic [1:0] q;
  logic [3:0] bitn;
  logic ack_in;
  logic [7:0] tx;

  always_comb begin
    unique case (step)
      S_HSC: tx = HS_CODE_BYTE;
      S_ADR: tx = cmd[CMD_BCAST] ? BCAST_ADDR : {ADDR_FIXED, cmd[CMD_SEL], 1'b0};
      S_CTL: tx = {2'b00, data_reg[DATA_PD_LSB +: 2], data_reg[7:NIBBLE]};
      S_LOW: tx = {data_reg[NIBBLE-1:0], 4'h0};
    endcase
  end

  // Open-drain outputs; the out level stays low and enables do the work
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= H_IDLE;
      step <= S_ADR;
      q <= Q_SET;
      bitn <= 4'h0;
      ack_in <= 1'b1;
      nack <= 1'b0;
      open <= 1'b0;
      hs_active <= 1'b0;
      bus.host_scl_oe_n <= 1'b1;
      bus.host_sda_oe_n <= 1'b1;
      bus.host_scl_out <= 1'b0;
      bus.host_sda_out <= 1'b0;
    end else if (go) begin
      nack <= 1'b0;
      q <= Q_SET;
      bitn <= 4'h0;
      // A held frame takes just another byte pair
      state <= open ? H_BIT : H_START;
      // The command register loads at this same edge, so the flag comes off the bus
      step <= open ? S_CTL : (hwdata[CMD_HS] && !hs_active ? S_HSC : S_ADR);
    end else if (tick && state != H_IDLE) begin
      q <= q + 2'h1;
      unique case (state)
        H_START: begin
          if (q == Q_SET) bus.host_sda_oe_n <= 1'b1;
          if (q == Q_RISE) bus.host_scl_oe_n <= 1'b1;
          if (q == Q_MID) bus.host_sda_oe_n <= 1'b0;
          if (q == Q_FALL) begin
            bus.host_scl_oe_n <= 1'b0;
            state <= H_BIT;
            bitn <= 4'h0;
          end
        end
        H_BIT: begin
          // Data only moves in the first quarter, while the clock is held low
          if (q == Q_SET) begin
            bus.host_sda_oe_n <= bitn < BITS_PER_BYTE ? tx[3'(7 - bitn)] : 1'b1;
          end
          if (q == Q_RISE) bus.host_scl_oe_n <= 1'b1;
          if (q == Q_MID) ack_in <= bus.sda;
          if (q == Q_FALL) begin
            bus.host_scl_oe_n <= 1'b0;
            bitn <= bitn + 4'h1;
            if (bitn == BITS_PER_BYTE) begin
              bitn <= 4'h0;
              unique case (step)
                S_HSC: begin
                  hs_active <= 1'b1;
                  step <= S_ADR;
                  state <= H_START;
                end
                S_ADR, S_CTL: begin
                  step <= step == S_ADR ? S_CTL : S_LOW;
                  if (ack_in) begin
                    nack <= 1'b1;
                    state <= H_STOP;
                  end
                end
                S_LOW: begin
                  nack <= ack_in;
                  state <= (ack_in || cmd[CMD_STOP]) ? H_STOP : H_IDLE;
                  open <= !(ack_in || cmd[CMD_STOP]);
                end
              endcase
            end
          end
        end
        H_STOP: begin
          if (q == Q_SET) bus.host_sda_oe_n <= 1'b0;
          if (q == Q_RISE) bus.host_scl_oe_n <= 1'b1;
          if (q == Q_MID) bus.host_sda_oe_n <= 1'b1;
          if (q == Q_FALL) begin
            state <= H_IDLE;
            open <= 1'b0;
            hs_active <= 1'b0;
          end
        end
        H_IDLE: begin
          q <= Q_SET;
        end
      endcase
    end
  end
endmodule

// file: src/dac_link_if.sv
`timescale 1ns/100ps
interface dac_link_if;
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;

  // Pull-ups: a released line reads high, any driver may pull it low
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe_n,
                output host_sda_out, output host_sda_oe_n);
endinterface

// file: src/dac_link_pkg.sv
package dac_link_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_KHZ = 125000;
  localparam int FS_RATE_KHZ = 400;
  localparam int HS_RATE_KHZ = 3400;
  localparam int QUARTERS = 4;
  // Least quarter-period, rounded up so the bus never runs faster than allowed
  localparam logic [6:0] FS_QTR_CYC =
    7'((MCLK_KHZ + QUARTERS * FS_RATE_KHZ - 1) / (QUARTERS * FS_RATE_KHZ));
  localparam logic [6:0] HS_QTR_CYC =
    7'((MCLK_KHZ + QUARTERS * HS_RATE_KHZ - 1) / (QUARTERS * HS_RATE_KHZ));
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [1:0] Q_SET = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_MID = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [5:0] ADDR_FIXED = 6'h26;
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_CODE_BYTE = 8'h08;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CTRL_PD_LSB = 4;
  localparam int NIBBLE = 4;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ = 2'h3;

  // ----------------------------------------
  // Controller registers
  // ----------------------------------------
  localparam logic [31:0] REG_CMD = 32'h0000_0000;
  localparam logic [31:0] REG_DATA = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam int CMD_GO = 0;
  localparam int CMD_HS = 1;
  localparam int CMD_BCAST = 2;
  localparam int CMD_SEL = 3;
  localparam int CMD_STOP = 4;
  localparam int CMD_W = 5;
  localparam int DATA_PD_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_HS = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    D_IDLE = 2'b00, D_RECV = 2'b01, D_ACK = 2'b10, D_SKIP = 2'b11
  } dev_state_t;
  typedef enum logic [1:0] {
    P_ADDR = 2'b00, P_CTRL = 2'b01, P_LOW = 2'b10
  } dev_phase_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
  } host_state_t;
  typedef enum logic [1:0] {
    S_HSC = 2'b00, S_ADR = 2'b01, S_CTL = 2'b10, S_LOW = 2'b11
  } host_step_t;
endpackage

// file: src/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  // Two flops; idle bus level is high, so reset to ones
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= '1;
      q <= '1;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule
